//--- logic/strap_pkg.sv
// Constants, register map, states and mode decode for the strap latch.
// Assumes a 100 MHz clk and a plain strobe register port.
// Overview of operation
// - On leaving reset, sample both shared mode straps into internal registers.
// - During initialization keep both shared strap pins as undriven inputs.
// - After firmware starts, drive fault indicator and supply sync on those pins.
// - Hold the captured mode until power-down or the next reset.
// - Do not latch topology straps; power stage uses their live levels.
// - Decode each two-bit strap pair into one of four modes 00..11.
// - Modes 2 and 3 insert high and low pass crossover filtering.
// - Fault output is active low, reporting only after firmware initialization.
package strap_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_DIV    = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;

  localparam int unsigned CTRL_RUN   = 0;
  localparam int unsigned CTRL_FAULT = 1;
  localparam int unsigned CTRL_SYNC  = 2;
  localparam logic [2:0]  CTRL_RESET = 3'h0;

  localparam int unsigned DIV_W               = 16;
  localparam logic [15:0] DIV_RESET           = 16'h0031;

  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_TOPO_LSB  = 2;
  localparam int unsigned ST_MISMATCH  = 4;
  localparam int unsigned ST_CAPTURED  = 5;
  localparam int unsigned ST_RUNNING   = 6;
  localparam int unsigned ST_FAULT_REQ = 7;
  localparam int unsigned ST_XOVER     = 8;

  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned SETTLE_NS     = 1000;
  localparam int unsigned SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SETTLE_W      = 8;

  typedef enum logic [1:0] {
    MODE_FB2   = 2'b00,
    MODE_FB2_L = 2'b01,
    MODE_HB2_S = 2'b10,
    MODE_HB4   = 2'b11
  } mode_t;

  typedef enum logic [1:0] {
    PH_SETTLE  = 2'b00,
    PH_CAPTURE = 2'b01,
    PH_INIT    = 2'b10,
    PH_RUN     = 2'b11
  } phase_t;

  // Half-bridge mask of outputs A..D for a mode
  function automatic logic [3:0] halfbridge_mask(input logic [1:0] m);
    case (m)
      MODE_HB2_S: halfbridge_mask = 4'h3;
      MODE_HB4:   halfbridge_mask = 4'hF;
      default:    halfbridge_mask = 4'h0;
    endcase
  endfunction : halfbridge_mask

endpackage : strap_pkg

//--- logic/mode_if.sv
// Carries the latched and live modes to the decoder and its results back.
// Assumes one clock domain; all members are plain levels.
`timescale 1ns/1ns
interface mode_if;
  logic [1:0] mode_latched;
  logic [1:0] topo_live;
  logic [3:0] stage_hb;
  logic       full_ab;
  logic       full_cd;
  logic       line_en;
  logic       sub_en;
  logic       xover_en;
  logic [2:0] audio_chans;

  modport src (output mode_latched, output topo_live,
               input stage_hb, input full_ab, input full_cd, input line_en,
               input sub_en, input xover_en, input audio_chans);
  modport dec (input mode_latched, input topo_live,
               output stage_hb, output full_ab, output full_cd, output line_en,
               output sub_en, output xover_en, output audio_chans);
endinterface : mode_if

//--- logic/strap_sync.sv
// Two-flop synchronizer for strap pins of any width.
// Assumes asynchronous pins; only the second stage is read outside.
`timescale 1ns/1ns
module strap_sync #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Pins and synchronized levels
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);
  logic [WIDTH-1:0] meta_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("strap_sync WIDTH must be at least 1");
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      level  <= '0;
    end else begin
      meta_q <= pin;
      level  <= meta_q;
    end
  end
endmodule : strap_sync

//--- logic/mode_decoder.sv
// Turns the latched mode and live topology into path and stage controls.
// Assumes both modes are already stable synchronous levels.
`timescale 1ns/1ns
module mode_decoder (
  // Mode in, controls out
  mode_if.dec m
);
  // Power stage arrangement follows the live topology straps
  assign m.stage_hb = strap_pkg::halfbridge_mask(m.topo_live);
  assign m.full_ab  = (strap_pkg::halfbridge_mask(m.topo_live) == 4'h0);
  assign m.full_cd  = (m.topo_live != strap_pkg::MODE_HB4);

  // Audio paths follow the latched mode
  always_comb begin
    m.line_en     = 1'b0;
    m.sub_en      = 1'b0;
    m.xover_en    = 1'b0;
    m.audio_chans = 3'h2;
    case (m.mode_latched)
      strap_pkg::MODE_FB2: begin
        m.audio_chans = 3'h2;
      end
      strap_pkg::MODE_FB2_L: begin
        m.line_en     = 1'b1;
        m.sub_en      = 1'b1;
        m.audio_chans = 3'h5;
      end
      strap_pkg::MODE_HB2_S: begin
        m.line_en     = 1'b1;
        m.sub_en      = 1'b1;
        m.xover_en    = 1'b1;
        m.audio_chans = 3'h5;
      end
      strap_pkg::MODE_HB4: begin
        m.xover_en    = 1'b1;
        m.audio_chans = 3'h4;
      end
      default: begin
        m.audio_chans = 3'h2;
      end
    endcase
  end
endmodule : mode_decoder

//--- logic/config_strap_latch.sv
// Strap capture at reset release and pin hand-over to fault and supply sync.
// Assumes board straps on the pins and firmware setting the run bit.
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module config_strap_latch #(
  parameter int unsigned SETTLE_CYCLES = strap_pkg::SETTLE_CYCLES
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  // Topology straps, read live
  input  wire logic        stage_topology_strap_lo,
  input  wire logic        stage_topology_strap_hi,
  // Shared pin: mode strap low / fault indicator
  input  wire logic        fault_out_mode_strap_lo_in,
  output logic             fault_out_mode_strap_lo_out,
  output logic             fault_out_mode_strap_lo_oe_n,
  // Shared pin: mode strap high / supply sync
  input  wire logic        supply_sync_mode_strap_hi_in,
  output logic             supply_sync_out,
  output logic             supply_sync_mode_strap_hi_oe_n,
  // Protection request and decoded controls
  input  wire logic        fault_req,
  output logic [1:0]       mode,
  output logic [3:0]       stage_hb,
  output logic             full_ab,
  output logic             full_cd,
  output logic             line_en,
  output logic             sub_en,
  output logic             xover_en,
  output logic [2:0]       audio_chans,
  output logic             running
);
  if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << strap_pkg::SETTLE_W)) begin : g_bad_settle
    $error("SETTLE_CYCLES out of range");
  end

  logic [3:0] pins_s;
  logic [1:0] mode_q;
  logic [1:0] topo_q;
  logic       captured_q;
  logic [2:0] ctrl_q;
  logic [15:0] div_q;
  logic [15:0] div_cnt_q;
  logic       sync_q;
  logic [7:0] settle_q;
  logic       fault_out_n_q;
  logic       drive_q;
  strap_pkg::phase_t phase_q;
  strap_pkg::phase_t phase_d;

  // Pins pass two flops before use
  strap_sync #(.WIDTH(4)) u_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({stage_topology_strap_hi, stage_topology_strap_lo,
             supply_sync_mode_strap_hi_in, fault_out_mode_strap_lo_in}),
    .level (pins_s)
  );

  // Phase sequencer: settle, capture once, init, run
  always_comb begin
    phase_d = phase_q;
    case (phase_q)
      strap_pkg::PH_SETTLE: begin
        if (settle_q == 8'(SETTLE_CYCLES - 1)) phase_d = strap_pkg::PH_CAPTURE;
      end
      strap_pkg::PH_CAPTURE: begin
        phase_d = strap_pkg::PH_INIT;
      end
      strap_pkg::PH_INIT: begin
        if (ctrl_q[strap_pkg::CTRL_RUN]) phase_d = strap_pkg::PH_RUN;
      end
      strap_pkg::PH_RUN: begin
        phase_d = strap_pkg::PH_RUN;
      end
      default: begin
        phase_d = strap_pkg::PH_SETTLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_q <= strap_pkg::PH_SETTLE;
    end else begin
      phase_q <= phase_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      settle_q <= 8'h00;
    end else if (phase_q == strap_pkg::PH_SETTLE) begin
      settle_q <= settle_q + 8'h01;
    end
  end

  // Mode capture: once per reset, held afterwards
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q     <= 2'h0;
      captured_q <= 1'b0;
    end else if (phase_q == strap_pkg::PH_CAPTURE) begin
      mode_q     <= pins_s[1:0];
      captured_q <= 1'b1;
    end
  end

  // Topology straps follow the pins every cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      topo_q <= 2'h0;
    end else begin
      topo_q <= pins_s[3:2];
    end
  end

  // Control register; run bit is sticky until reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= strap_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == strap_pkg::REG_CTRL) begin
      ctrl_q[strap_pkg::CTRL_RUN]   <= ctrl_q[strap_pkg::CTRL_RUN] | reg_wdata[strap_pkg::CTRL_RUN];
      ctrl_q[strap_pkg::CTRL_FAULT] <= reg_wdata[strap_pkg::CTRL_FAULT];
      ctrl_q[strap_pkg::CTRL_SYNC]  <= reg_wdata[strap_pkg::CTRL_SYNC];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_q <= strap_pkg::DIV_RESET;
    end else if (reg_wr && reg_addr == strap_pkg::REG_DIV) begin
      div_q <= reg_wdata[strap_pkg::DIV_W-1:0];
    end
  end

  // Supply sync square wave: toggles every div_q+1 cycles
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt_q <= 16'h0000;
      sync_q    <= 1'b0;
    end else if (!ctrl_q[strap_pkg::CTRL_SYNC] || phase_q != strap_pkg::PH_RUN) begin
      div_cnt_q <= 16'h0000;
      sync_q    <= 1'b0;
    end else if (div_cnt_q >= div_q) begin
      div_cnt_q <= 16'h0000;
      sync_q    <= ~sync_q;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // Pin drivers: inputs until running, then outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drive_q       <= 1'b0;
      fault_out_n_q <= 1'b1;
    end else begin
      drive_q       <= (phase_q == strap_pkg::PH_RUN);
      fault_out_n_q <= ~((fault_req | ctrl_q[strap_pkg::CTRL_FAULT]) &&
                         phase_q == strap_pkg::PH_RUN);
    end
  end

  assign fault_out_mode_strap_lo_oe_n   = ~drive_q;
  assign supply_sync_mode_strap_hi_oe_n = ~drive_q;
  assign fault_out_mode_strap_lo_out    = fault_out_n_q;
  assign supply_sync_out                = sync_q;
  assign running                        = drive_q;

  // Decode of latched mode and live topology
  mode_if mi ();
  assign mi.mode_latched = mode_q;
  assign mi.topo_live    = topo_q;

  mode_decoder u_dec (
    .m (mi.dec)
  );

  assign mode        = mode_q;
  assign stage_hb    = mi.stage_hb;
  assign full_ab     = mi.full_ab;
  assign full_cd     = mi.full_cd;
  assign line_en     = mi.line_en;
  assign sub_en      = mi.sub_en;
  assign xover_en    = mi.xover_en;
  assign audio_chans = mi.audio_chans;

  // Register reads, data one cycle after the strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        strap_pkg::REG_CTRL:   reg_rdata <= {29'h0, ctrl_q};
        strap_pkg::REG_DIV:    reg_rdata <= {16'h0, div_q};
        strap_pkg::REG_STATUS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[strap_pkg::ST_MODE_LSB +: 2] <= mode_q;
          reg_rdata[strap_pkg::ST_TOPO_LSB +: 2] <= topo_q;
          reg_rdata[strap_pkg::ST_MISMATCH]      <= captured_q && (mode_q != topo_q);
          reg_rdata[strap_pkg::ST_CAPTURED]      <= captured_q;
          reg_rdata[strap_pkg::ST_RUNNING]       <= drive_q;
          reg_rdata[strap_pkg::ST_FAULT_REQ]     <= fault_req;
          reg_rdata[strap_pkg::ST_XOVER]         <= mi.xover_en;
        end
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : config_strap_latch

//--- test/strap_board.sv
// Board strap resistors on the two shared mode pins.
// Assumes the device oe_n is low while it drives a pin.
`timescale 1ns/1ns
module strap_board (
  // Strap levels set by the bench
  input  wire logic pull_lo,
  input  wire logic pull_hi,
  // Device side of the shared pins
  input  wire logic out_lo,
  input  wire logic oe_n_lo,
  input  wire logic out_hi,
  input  wire logic oe_n_hi,
  output logic      pin_lo,
  output logic      pin_hi
);
  // Resistor sets the level unless the device drives
  assign pin_lo = oe_n_lo ? pull_lo : out_lo;
  assign pin_hi = oe_n_hi ? pull_hi : out_hi;
endmodule : strap_board

//--- test/strap_latch_props.sv
// Checker of the strap latch top-level ports.
// Assumes it is bound onto config_strap_latch.
`timescale 1ns/1ns
module strap_latch_props (
  // Clock, reset and register writes
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  // Straps and shared pins
  input wire logic        stage_topology_strap_lo,
  input wire logic        stage_topology_strap_hi,
  input wire logic        fault_out_mode_strap_lo_in,
  input wire logic        fault_out_mode_strap_lo_out,
  input wire logic        fault_out_mode_strap_lo_oe_n,
  input wire logic        supply_sync_mode_strap_hi_in,
  input wire logic        supply_sync_mode_strap_hi_oe_n,
  // Fault request and decoded outputs
  input wire logic        fault_req,
  input wire logic [1:0]  mode,
  input wire logic [3:0]  stage_hb,
  input wire logic        line_en,
  input wire logic        xover_en,
  input wire logic [2:0]  audio_chans,
  input wire logic        running
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_idle_in;
    !running |-> fault_out_mode_strap_lo_oe_n && supply_sync_mode_strap_hi_oe_n && fault_out_mode_strap_lo_out;
  endproperty
  a_idle_in: assert property (p_idle_in) else $error("shared pin driven before run");

  property p_run_out;
    running |-> !fault_out_mode_strap_lo_oe_n && !supply_sync_mode_strap_hi_oe_n;
  endproperty
  a_run_out: assert property (p_run_out) else $error("shared pin not driven in run");

  property p_run_start;
    reg_wr && reg_addr == strap_pkg::REG_CTRL && reg_wdata[strap_pkg::CTRL_RUN] |-> ##[1:300] running;
  endproperty
  a_run_start: assert property (p_run_start) else $error("run never started");

  property p_capture;
    $rose(running) |-> mode == {$past(supply_sync_mode_strap_hi_in), $past(fault_out_mode_strap_lo_in)};
  endproperty
  a_capture: assert property (p_capture) else $error("mode differs from straps");

  property p_mode_hold;
    running && $past(running) |-> $stable(mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode changed in run");

  property p_topo;
    $rose(stage_topology_strap_hi) && stage_topology_strap_lo |-> ##3 stage_hb == 4'hF;
  endproperty
  a_topo: assert property (p_topo) else $error("stage mask not following topology");

  property p_decode;
    audio_chans == (mode == 2'h0 ? 3'h2 : mode == 2'h3 ? 3'h4 : 3'h5) && line_en == (mode == 2'h1 || mode == 2'h2);
  endproperty
  a_decode: assert property (p_decode) else $error("mode decode wrong");

  property p_xover;
    xover_en == mode[1];
  endproperty
  a_xover: assert property (p_xover) else $error("crossover enable wrong");

  property p_fault;
    running && fault_req |=> !fault_out_mode_strap_lo_out;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not reported low");
endmodule : strap_latch_props

bind config_strap_latch strap_latch_props u_props (.*);

//--- test/config_strap_latch_bench.sv
// Self-checking bench of the strap latch.
// Assumes strap_pkg, the design and strap_board are compiled first.
`timescale 1ns/1ns
module config_strap_latch_bench;
  localparam int unsigned SETTLE = 2;
  logic        clk, rst, reg_wr, reg_rd, topo_lo, topo_hi, fault_req, pull_lo, pull_hi;
  logic        fault_in, fault_out, fault_oe_n, sync_in, sync_out, sync_oe_n, line_en, xover_en, running;
  logic        sub_en, full_ab, full_cd;
  logic [3:0]  reg_addr, stage_hb;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [1:0]  mode;
  logic [2:0]  audio_chans;
  int          fail_count, samples_checked, cycles;

  config_strap_latch #(.SETTLE_CYCLES(SETTLE)) DUT (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stage_topology_strap_lo(topo_lo), .stage_topology_strap_hi(topo_hi),
    .fault_out_mode_strap_lo_in(fault_in), .fault_out_mode_strap_lo_out(fault_out),
    .fault_out_mode_strap_lo_oe_n(fault_oe_n), .supply_sync_mode_strap_hi_in(sync_in),
    .supply_sync_out(sync_out), .supply_sync_mode_strap_hi_oe_n(sync_oe_n), .fault_req(fault_req),
    .mode(mode), .stage_hb(stage_hb), .full_ab(full_ab), .full_cd(full_cd), .line_en(line_en), .sub_en(sub_en),
    .xover_en(xover_en), .audio_chans(audio_chans), .running(running));
  strap_board u_board (.pull_lo(pull_lo), .pull_hi(pull_hi), .out_lo(fault_out), .oe_n_lo(fault_oe_n),
    .out_hi(sync_out), .oe_n_hi(sync_oe_n), .pin_lo(fault_in), .pin_hi(sync_in));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input bit ok, input string what);
    samples_checked++;
    if (!ok) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // Both strap pairs set alike, then reset and settle
  task automatic boot(input logic [1:0] m);
    @(posedge clk);
    pull_lo <= m[0];
    pull_hi <= m[1];
    topo_lo <= m[0];
    topo_hi <= m[1];
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (SETTLE + 10) @(posedge clk);
  endtask : boot

  task automatic t_regs;
    boot(2'h2);
    rd(strap_pkg::REG_DIV);
    chk(d === 32'h0000_0031, "divider reset value");
    wr(4'hC, 32'h0000_0005);
    rd(4'hC);
    chk(d === 32'h0000_0000, "unmapped read");
    rd(strap_pkg::REG_STATUS);
    chk(d === 32'h0000_012A, "status before run");
    $display("test regs done");
  endtask : t_regs

  task automatic t_mode(input logic [1:0] m);
    boot(m);
    chk(fault_oe_n === 1'b1 && sync_oe_n === 1'b1, "pins driven in init");
    wr(strap_pkg::REG_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    #1 chk(running === 1'b1 && fault_oe_n === 1'b0 && sync_oe_n === 1'b0, "pins not handed over");
    chk(mode === m, "captured mode");
    chk(xover_en === m[1], "crossover");
    chk(audio_chans === (m == 2'h0 ? 3'h2 : m == 2'h3 ? 3'h4 : 3'h5), "channel count");
    chk(line_en === (m == 2'h1 || m == 2'h2), "line outputs");
    chk(sub_en === (m == 2'h1 || m == 2'h2), "sub output");
    chk(fault_out === 1'b1, "fault idle level");
    $display("test mode %0d done", m);
  endtask : t_mode

  task automatic t_fault;
    @(posedge clk);
    fault_req <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(fault_out === 1'b0, "fault request not shown");
    @(posedge clk);
    fault_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(fault_out === 1'b1, "fault not released");
    wr(strap_pkg::REG_CTRL, 32'h0000_0003);
    repeat (2) @(posedge clk);
    #1 chk(fault_out === 1'b0, "forced fault not shown");
    chk(mode === 2'h3, "mode lost on pin activity");
    $display("test fault done");
  endtask : t_fault

  task automatic t_sync;
    int   n;
    logic prev;
    n = 0;
    wr(strap_pkg::REG_DIV, 32'h0000_0001);
    wr(strap_pkg::REG_CTRL, 32'h0000_0005);
    repeat (4) @(posedge clk);
    #1 prev = sync_out;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      #1 if (sync_out !== prev) n++;
      prev = sync_out;
    end
    chk(n == 20, "sync toggle rate");
    chk(mode === 2'h3, "mode lost on sync activity");
    $display("test sync done");
  endtask : t_sync

  task automatic t_topo;
    logic [1:0] t;
    for (int i = 0; i < 4; i++) begin
      t = {i[0], i[1]};
      @(posedge clk);
      topo_lo <= t[0];
      topo_hi <= t[1];
      repeat (4) @(posedge clk);
      #1 chk(stage_hb === (t == 2'h3 ? 4'hF : t == 2'h2 ? 4'h3 : 4'h0), "live topology");
      chk(full_ab === (t[1] == 1'b0) && full_cd === (t != 2'h3), "full bridge flags");
      rd(strap_pkg::REG_STATUS);
      chk(d === {23'h0, 1'b1, 1'b0, 1'b1, 1'b1, t != 2'h3, t, 2'h3}, "status in run");
    end
    $display("test topology done");
  endtask : t_topo

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    {rst, reg_wr, reg_rd, topo_lo, topo_hi, fault_req, pull_lo, pull_hi} = 8'h80;
    reg_addr = 4'h0;
    reg_wdata = 32'h0000_0000;
    t_regs();
    for (int m = 0; m < 4; m++) t_mode(m[1:0]);
    t_fault();
    t_sync();
    t_topo();
    wrap_up();
  end
endmodule : config_strap_latch_bench
